/* tcp_pkg.sv */
// Shared constants, types and word arithmetic of the transmit command parser
package tcp_pkg;
	// Widths
	localparam int WORD_W = 32;
	localparam int TAG_W = 16;
	localparam int SIZE_W = 11;
	localparam int OFF_W = 5;
	localparam int CNT_W = 10;
	localparam int FREE_W = 16;
	localparam int SUM_W = 16;
	localparam int BYTE_W = 12;
	localparam int LANES = 4;
	localparam int FIFO_DEPTH = 64;
	// Command word A fields
	localparam int A_IOC_BIT = 31;
	localparam int A_ALIGN_LO = 24;
	localparam int A_OFF_LO = 16;
	localparam int A_FIRST_SEGMENT_BIT = 13;
	localparam int A_LS_BIT = 12;
	localparam int A_SIZE_LO = 0;
	localparam logic [WORD_W-1:0] A_RSV_MASK = 32'h7C00_0000;
	// Command word B fields
	localparam int B_TAG_LO = 16;
	localparam int B_LEN_LO = 0;
	// End alignment codes and their word masks
	localparam logic [1:0] ALIGN_4 = 2'h0;
	localparam logic [1:0] ALIGN_16 = 2'h1;
	localparam logic [1:0] ALIGN_32 = 2'h2;
	localparam logic [1:0] ALIGN_RSV = 2'h3;
	localparam logic [CNT_W-1:0] ALIGN16_MASK = 10'h003;
	localparam logic [CNT_W-1:0] ALIGN32_MASK = 10'h007;
	// Host controller register offsets
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CMD_A = 8'h00;
	localparam logic [ADDR_W-1:0] REG_CMD_B = 8'h04;
	localparam logic [ADDR_W-1:0] REG_DATA = 8'h08;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] REG_MASK = 8'h14;
	localparam logic [ADDR_W-1:0] REG_FREE = 8'h18;
	localparam logic [ADDR_W-1:0] REG_TAG = 8'h1C;
	// Control and status bits
	localparam int CTRL_SEND_BIT = 0;
	localparam int CTRL_PAD_BIT = 1;
	localparam int EVT_W = 3;
	localparam int EVT_LOADED = 0;
	localparam int EVT_ERROR = 1;
	localparam int EVT_STATUS = 2;
	localparam logic [EVT_W-1:0] MASK_RST = 3'h0;
	// State machines
	typedef enum logic [1:0] {DEV_CMD_A, DEV_CMD_B, DEV_DATA} tcp_dev_state_t;
	typedef enum logic [1:0] {HOST_IDLE, HOST_SEND_B, HOST_PAD} tcp_host_state_t;

	// Words a buffer occupies on the link after its two command words
	function automatic logic [CNT_W-1:0] tcp_total_words(input logic [SIZE_W-1:0] size,
		input logic [OFF_W-1:0] off, input logic [1:0] align);
		logic [BYTE_W-1:0] bytes;
		logic [CNT_W-1:0] dw;
		logic [CNT_W-1:0] am;
		bytes = {1'b0, size} + {7'h00, off};
		dw = CNT_W'((bytes + 12'h003) >> 2);
		am = (align == ALIGN_16) ? ALIGN16_MASK : (align == ALIGN_32) ? ALIGN32_MASK : 10'h000;
		return (dw + am) & ~am;
	endfunction
endpackage

/* tcp_link_if.sv */
// Dword link between the host controller and the command parser
`timescale 1ns/1ps
`default_nettype none
interface tcp_link_if;
	logic dw_valid;
	logic [tcp_pkg::WORD_W-1:0] dw_data;
	logic [tcp_pkg::FREE_W-1:0] free_words;
	logic loaded_evt;
	logic error_evt;
	logic stat_valid;
	logic [tcp_pkg::TAG_W-1:0] stat_tag;
	modport host (output dw_valid, output dw_data, input free_words, input loaded_evt,
		input error_evt, input stat_valid, input stat_tag);
	modport dev (input dw_valid, input dw_data, output free_words, output loaded_evt,
		output error_evt, output stat_valid, output stat_tag);
endinterface
`default_nettype wire

/* tcp_word_fifo.sv */
// Transmit data FIFO with a registered output stage
`timescale 1ns/1ps
`default_nettype none
module tcp_word_fifo #(
	parameter int W = 36,
	parameter int DEPTH = 64
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready,
	// Occupancy, output stage included
	output logic [$clog2(DEPTH)+1:0] used
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic ov;
		logic [W-1:0] od;
	} tcp_fifo_reg_t;

	tcp_fifo_reg_t cur;
	tcp_fifo_reg_t next_cur;
	logic [W-1:0] mem [DEPTH];
	logic push;
	logic pop;

	// DEPTH must be a power of two so the pointers wrap by themselves
	// Output stage counts against DEPTH, so the free count never goes below zero
	assign in_ready = (used < (AW+2)'(DEPTH));
	assign push = in_valid && in_ready;
	assign pop = (cur.cnt != '0) && (!cur.ov || out_ready);
	assign out_valid = cur.ov;
	assign out_data = cur.od;
	assign used = {1'b0, cur.cnt} + {{(AW+1){1'b0}}, cur.ov};

	// Pointer and output stage update
	always_comb begin
		next_cur = cur;
		if (cur.ov && out_ready) begin
			next_cur.ov = 1'b0;
		end
		if (pop) begin
			next_cur.ov = 1'b1;
			next_cur.od = mem[cur.rp];
			next_cur.rp = cur.rp + 1'b1;
		end
		if (push) begin
			next_cur.wp = cur.wp + 1'b1;
		end
		next_cur.cnt = cur.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// Storage has no reset; only slots behind the count are ever read
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[cur.wp] <= in_data;
		end
	end
endmodule
`default_nettype wire

/* tcp_dev_end.sv */
// Transmit command parser: splits command words, strips offset and padding, checks packets
// Summary of operation
// - Host sends command words before buffer payload
// - Command is two 32-bit words, A then B
// - Host sends A and B for every buffer
// - Word B mismatch within a packet flags error
// - Packet tag returned with packet status
// - Interrupt-on-completion bit pulses buffer loaded flag
// - Host writes zero to A bits 30:26
// - A bits 25:24 select 4/16/32-byte end alignment
// - Host pads to alignment; device drops padding
// - Command words and padding never reach FIFO
// - A bits 20:16 offset; earlier bytes ignored
// - Summed buffer sizes must equal packet length
// - Writing into a full FIFO flags error
`timescale 1ns/1ps
`default_nettype none
module tcp_dev_end #(
	parameter int DEPTH = tcp_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Link from the host
	tcp_link_if.dev link,
	// Payload towards the transmitter
	output logic rd_valid,
	output logic [tcp_pkg::WORD_W-1:0] rd_data,
	output logic [tcp_pkg::LANES-1:0] rd_mask,
	input wire logic rd_ready,
	// Flags
	output logic tx_error_flag,
	input wire logic err_clear,
	output logic buffer_loaded_flag
);
	localparam int FW = tcp_pkg::WORD_W + tcp_pkg::LANES;

	typedef struct packed {
		tcp_pkg::tcp_dev_state_t st;
		logic ioc;
		logic [1:0] align;
		logic [tcp_pkg::OFF_W-1:0] off;
		logic [tcp_pkg::SIZE_W-1:0] size;
		logic first_segment_bit;
		logic ls;
		logic [tcp_pkg::WORD_W-1:0] cmd_b;
		logic b_open;
		logic [tcp_pkg::SUM_W-1:0] sum;
		logic [tcp_pkg::CNT_W-1:0] widx;
		logic [tcp_pkg::CNT_W-1:0] total;
		logic push;
		logic [FW-1:0] push_data;
		logic err_evt;
		logic loaded_evt;
		logic stat_valid;
		logic [tcp_pkg::TAG_W-1:0] stat_tag;
		logic tx_error_flag;
		logic [tcp_pkg::FREE_W-1:0] free;
	} tcp_dev_reg_t;

	tcp_dev_reg_t cur;
	tcp_dev_reg_t next_cur;
	logic fifo_ready;
	logic fifo_valid;
	logic [FW-1:0] fifo_data;
	logic [$clog2(DEPTH)+1:0] fifo_used;
	logic [tcp_pkg::BYTE_W-1:0] end_byte;
	logic [tcp_pkg::LANES-1:0] lanes;
	logic [tcp_pkg::SIZE_W-1:0] in_size;
	logic [tcp_pkg::OFF_W-1:0] in_off;
	logic [1:0] in_align;
	logic finish;
	logic err_set;

	// Byte lanes of one dword that fall inside the payload window
	function automatic logic [tcp_pkg::LANES-1:0] tcp_lane_mask(input logic [tcp_pkg::CNT_W-1:0] widx,
		input logic [tcp_pkg::OFF_W-1:0] off, input logic [tcp_pkg::BYTE_W-1:0] stop);
		logic [tcp_pkg::BYTE_W-1:0] pos;
		logic [tcp_pkg::LANES-1:0] m;
		m = '0;
		for (int i = 0; i < tcp_pkg::LANES; i++) begin
			pos = {widx, 2'b00} + tcp_pkg::BYTE_W'(i);
			m[i] = (pos >= {7'h00, off}) && (pos < stop);
		end
		return m;
	endfunction

	// Fields of an incoming command word A
	assign in_size = link.dw_data[tcp_pkg::A_SIZE_LO +: tcp_pkg::SIZE_W];
	assign in_off = link.dw_data[tcp_pkg::A_OFF_LO +: tcp_pkg::OFF_W];
	assign in_align = link.dw_data[tcp_pkg::A_ALIGN_LO +: 2];
	// First byte past the payload, counted from the first data word
	assign end_byte = {1'b0, cur.size} + {7'h00, cur.off};
	assign lanes = tcp_lane_mask(cur.widx, cur.off, end_byte);

	// Parser state machine
	always_comb begin
		next_cur = cur;
		next_cur.push = 1'b0;
		next_cur.err_evt = 1'b0;
		next_cur.loaded_evt = 1'b0;
		next_cur.stat_valid = 1'b0;
		finish = 1'b0;
		// A word pushed last cycle into a full FIFO is lost
		err_set = cur.push && !fifo_ready;
		if (link.dw_valid) begin
			case (cur.st)
				tcp_pkg::DEV_CMD_A: begin
					// Command words are consumed here and never pushed into the FIFO
					next_cur.ioc = link.dw_data[tcp_pkg::A_IOC_BIT];
					next_cur.align = in_align;
					next_cur.off = in_off;
					next_cur.size = in_size;
					next_cur.first_segment_bit = link.dw_data[tcp_pkg::A_FIRST_SEGMENT_BIT];
					next_cur.ls = link.dw_data[tcp_pkg::A_LS_BIT];
					next_cur.total = tcp_pkg::tcp_total_words(in_size, in_off, in_align);
					// Reserved code is not guessed at; it counts as one-dword alignment
					if (in_align == tcp_pkg::ALIGN_RSV) begin
						err_set = 1'b1;
					end
					next_cur.st = tcp_pkg::DEV_CMD_B;
				end
				tcp_pkg::DEV_CMD_B: begin
					// A first segment opens a packet; later segments must repeat word B
					if (cur.first_segment_bit || !cur.b_open) begin
						next_cur.cmd_b = link.dw_data;
						next_cur.sum = {5'h00, cur.size};
					end else begin
						if (link.dw_data != cur.cmd_b) begin
							err_set = 1'b1;
						end
						next_cur.sum = cur.sum + {5'h00, cur.size};
					end
					next_cur.b_open = 1'b1;
					next_cur.widx = '0;
					if (cur.total == '0) begin
						finish = 1'b1;
					end else begin
						next_cur.st = tcp_pkg::DEV_DATA;
					end
				end
				tcp_pkg::DEV_DATA: begin
					// Offset bytes and padding dwords carry no valid lane and are dropped
					if (lanes != '0) begin
						next_cur.push = 1'b1;
						next_cur.push_data = {lanes, link.dw_data};
					end
					next_cur.widx = cur.widx + 1'b1;
					if (cur.widx + 1'b1 == cur.total) begin
						finish = 1'b1;
					end
				end
				default: begin
					next_cur.st = tcp_pkg::DEV_CMD_A;
				end
			endcase
		end
		// End of one buffer
		if (finish) begin
			next_cur.st = tcp_pkg::DEV_CMD_A;
			next_cur.loaded_evt = cur.ioc;
			if (cur.ls) begin
				next_cur.b_open = 1'b0;
				next_cur.stat_valid = 1'b1;
				next_cur.stat_tag = next_cur.cmd_b[tcp_pkg::B_TAG_LO +: tcp_pkg::TAG_W];
				if (next_cur.sum != {5'h00, next_cur.cmd_b[tcp_pkg::B_LEN_LO +: tcp_pkg::SIZE_W]}) begin
					err_set = 1'b1;
				end
			end
		end
		// Error flag: a new error wins over a clear in the same cycle
		next_cur.err_evt = err_set;
		next_cur.tx_error_flag = err_set || (cur.tx_error_flag && !err_clear);
		// Free space as seen by the host, one cycle old
		next_cur.free = tcp_pkg::FREE_W'(DEPTH) - tcp_pkg::FREE_W'(fifo_used);
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// Payload storage; the pushed word is checked against full one cycle later
	tcp_word_fifo #(
		.W(FW),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.in_valid(cur.push),
		.in_data(cur.push_data),
		.in_ready(fifo_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(rd_ready),
		.used(fifo_used)
	);

	// Outputs, all from flip-flops
	assign rd_valid = fifo_valid;
	assign rd_data = fifo_data[tcp_pkg::WORD_W-1:0];
	assign rd_mask = fifo_data[FW-1:tcp_pkg::WORD_W];
	assign tx_error_flag = cur.tx_error_flag;
	assign buffer_loaded_flag = cur.loaded_evt;
	assign link.free_words = cur.free;
	assign link.loaded_evt = cur.loaded_evt;
	assign link.error_evt = cur.err_evt;
	assign link.stat_valid = cur.stat_valid;
	assign link.stat_tag = cur.stat_tag;
endmodule
`default_nettype wire

/* tcp_host_end.sv */
// Host controller: sends command words, payload and padding on the link
`timescale 1ns/1ps
`default_nettype none
module tcp_host_end (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Link to the parser
	tcp_link_if.host link,
	// Software register port
	input wire logic [tcp_pkg::ADDR_W-1:0] addr,
	input wire logic [tcp_pkg::WORD_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [tcp_pkg::WORD_W-1:0] rdata,
	// Interrupt
	output logic irq
);
	typedef struct packed {
		tcp_pkg::tcp_host_state_t st;
		logic [tcp_pkg::WORD_W-1:0] cmd_a;
		logic [tcp_pkg::WORD_W-1:0] cmd_b;
		logic [tcp_pkg::EVT_W-1:0] status;
		logic [tcp_pkg::EVT_W-1:0] mask;
		logic [tcp_pkg::TAG_W-1:0] tag;
		logic dw_valid;
		logic [tcp_pkg::WORD_W-1:0] dw_data;
		logic [tcp_pkg::CNT_W-1:0] sent;
		logic [tcp_pkg::CNT_W-1:0] target;
		logic [tcp_pkg::WORD_W-1:0] rdata;
		logic irq;
	} tcp_host_reg_t;

	tcp_host_reg_t cur;
	tcp_host_reg_t next_cur;
	logic idle;
	logic [tcp_pkg::EVT_W-1:0] evt;
	logic [tcp_pkg::EVT_W-1:0] clr;

	assign idle = (cur.st == tcp_pkg::HOST_IDLE);
	assign evt = {link.stat_valid, link.error_evt, link.loaded_evt};
	assign clr = (wr && addr == tcp_pkg::REG_STATUS) ? wdata[tcp_pkg::EVT_W-1:0] : '0;

	// Sequencer, register writes and reads
	always_comb begin
		next_cur = cur;
		next_cur.dw_valid = 1'b0;
		next_cur.rdata = '0;
		case (cur.st)
			tcp_pkg::HOST_IDLE: begin
			end
			tcp_pkg::HOST_SEND_B: begin
				// Word B follows word A on the very next cycle
				next_cur.dw_valid = 1'b1;
				next_cur.dw_data = cur.cmd_b;
				next_cur.st = tcp_pkg::HOST_IDLE;
			end
			tcp_pkg::HOST_PAD: begin
				// Zero dwords up to the end alignment
				next_cur.dw_valid = 1'b1;
				next_cur.dw_data = '0;
				next_cur.sent = cur.sent + 1'b1;
				if (cur.sent + 1'b1 >= cur.target) begin
					next_cur.st = tcp_pkg::HOST_IDLE;
				end
			end
			default: begin
				next_cur.st = tcp_pkg::HOST_IDLE;
			end
		endcase
		if (wr) begin
			case (addr)
				tcp_pkg::REG_CMD_A: next_cur.cmd_a = wdata;
				tcp_pkg::REG_CMD_B: next_cur.cmd_b = wdata;
				tcp_pkg::REG_MASK: next_cur.mask = wdata[tcp_pkg::EVT_W-1:0];
				tcp_pkg::REG_DATA: begin
					// Payload goes out in any idle cycle, with or without a command before it; ignored while busy
					if (idle) begin
						next_cur.dw_valid = 1'b1;
						next_cur.dw_data = wdata;
						next_cur.sent = cur.sent + 1'b1;
					end
				end
				tcp_pkg::REG_CTRL: begin
					if (idle && wdata[tcp_pkg::CTRL_SEND_BIT]) begin
						next_cur.dw_valid = 1'b1;
						next_cur.dw_data = cur.cmd_a & ~tcp_pkg::A_RSV_MASK;
						next_cur.sent = '0;
						next_cur.target = tcp_pkg::tcp_total_words(
							cur.cmd_a[tcp_pkg::A_SIZE_LO +: tcp_pkg::SIZE_W],
							cur.cmd_a[tcp_pkg::A_OFF_LO +: tcp_pkg::OFF_W],
							cur.cmd_a[tcp_pkg::A_ALIGN_LO +: 2]);
						next_cur.st = tcp_pkg::HOST_SEND_B;
					end else if (idle && wdata[tcp_pkg::CTRL_PAD_BIT] && cur.sent < cur.target) begin
						next_cur.st = tcp_pkg::HOST_PAD;
					end
				end
				default: begin
				end
			endcase
		end
		if (rd) begin
			case (addr)
				tcp_pkg::REG_CMD_A: next_cur.rdata = cur.cmd_a;
				tcp_pkg::REG_CMD_B: next_cur.rdata = cur.cmd_b;
				tcp_pkg::REG_STATUS: next_cur.rdata = {28'h0000000, !idle, cur.status};
				tcp_pkg::REG_MASK: next_cur.rdata = {29'h00000000, cur.mask};
				tcp_pkg::REG_FREE: next_cur.rdata = {16'h0000, link.free_words};
				tcp_pkg::REG_TAG: next_cur.rdata = {16'h0000, cur.tag};
				default: next_cur.rdata = '0;
			endcase
		end
		// Sticky events; an event in the cycle of its clear survives
		if (link.stat_valid) begin
			next_cur.tag = link.stat_tag;
		end
		next_cur.status = evt | (cur.status & ~clr);
		next_cur.irq = |(next_cur.status & next_cur.mask);
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cur <= '0;
			cur.mask <= tcp_pkg::MASK_RST;
		end else begin
			cur <= next_cur;
		end
	end

	assign link.dw_valid = cur.dw_valid;
	assign link.dw_data = cur.dw_data;
	assign rdata = cur.rdata;
	assign irq = cur.irq;
endmodule
`default_nettype wire

/* tcp_link_chk.sv */
// Concurrent checks on the dword link between host controller and command parser
`timescale 1ns/1ps
`default_nettype none
module tcp_link_chk #(
	parameter int DEPTH = 64
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Link signals
	input wire logic dw_valid,
	input wire logic [31:0] dw_data,
	input wire logic [15:0] free_words,
	input wire logic loaded_evt,
	input wire logic error_evt,
	input wire logic stat_valid,
	input wire logic [15:0] stat_tag
);
	logic [1:0] st;
	logic [9:0] rem;
	logic [9:0] tot_a;
	logic [9:0] dw;
	logic [9:0] am;
	logic [11:0] nb;
	logic ioc;
	logic ls;
	logic nfs;
	logic open;
	logic [15:0] sum;
	logic [31:0] pkt_b;
	logic [31:0] b_now;
	logic fin;
	// Words announced by an A word; reserved code rounds like 4-byte alignment
	always_comb begin
		nb = {1'b0, dw_data[10:0]} + {7'h00, dw_data[20:16]};
		dw = 10'((nb + 12'h003) >> 2);
		am = (dw_data[25:24] == 2'h1) ? 10'h003 : (dw_data[25:24] == 2'h2) ? 10'h007 : 10'h000;
		tot_a = (dw + am) & ~am;
	end
	// B of the open packet; a zero-word buffer finishes on its own B
	assign b_now = (st == 2'h1 && !nfs) ? dw_data : pkt_b;
	assign fin = dw_valid && ((st == 2'h2 && rem == 10'h001) || (st == 2'h1 && rem == 10'h000));
	// Reference walk of the command stream
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st <= 2'h0;
			open <= 1'b0;
		end else if (dw_valid) begin
			case (st)
				2'h0: begin
					st <= 2'h1;
					rem <= tot_a;
					ioc <= dw_data[31];
					ls <= dw_data[12];
					nfs <= !dw_data[13] && open;
					sum <= (dw_data[13] || !open) ? 16'(dw_data[10:0]) : sum + 16'(dw_data[10:0]);
					open <= 1'b1;
				end
				2'h1: begin
					st <= (rem == 10'h000) ? 2'h0 : 2'h2;
					if (!nfs) pkt_b <= dw_data;
					if (fin && ls) open <= 1'b0;
				end
				default: begin
					rem <= rem - 10'h001;
					if (rem == 10'h001) st <= 2'h0;
					if (fin && ls) open <= 1'b0;
				end
			endcase
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence s_cmd_a;
		dw_valid && st == 2'h0;
	endsequence
	sequence s_cmd_b;
		dw_valid && st == 2'h1;
	endsequence
	a_cmd_pair: assert property (s_cmd_a |=> s_cmd_b) else $error("word B did not follow word A");
	a_rsv_zero: assert property (s_cmd_a |-> dw_data[30:26] == 5'h00) else $error("reserved A bits set");
	a_loaded_ioc: assert property (loaded_evt == $past(fin && ioc)) else $error("loaded event wrong");
	a_status_last: assert property (stat_valid == $past(fin && ls)) else $error("status event wrong");
	a_tag_return: assert property (stat_valid |-> stat_tag == $past(b_now[31:16])) else $error("bad tag");
	a_rsv_align: assert property (s_cmd_a ##0 dw_data[25:24] == 2'h3 |=> error_evt) else $error("no align error");
	a_b_match: assert property (s_cmd_b ##0 (nfs && dw_data != pkt_b) |=> error_evt) else $error("no B error");
	a_len_sum: assert property (fin && ls && sum != {5'h00, b_now[10:0]} |=> error_evt) else $error("no length error");
	a_free_step: assert property (free_words <= 16'(DEPTH) && $past(free_words) <= free_words + 16'h0001)
		else $error("free count jumped");
endmodule
`default_nettype wire

/* tb_tx_command_buffer_parser.sv */
// Testbench joining host controller and command parser over the dword link
`timescale 1ns/1ps
`default_nettype none
module tb_tx_command_buffer_parser;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_ready = 1'b1;
	logic err_clear = 1'b0;
	logic [31:0] rdata;
	logic irq;
	logic rd_valid;
	logic [31:0] rd_data;
	logic [3:0] rd_mask;
	logic tx_error_flag;
	logic buffer_loaded_flag;
	logic [35:0] q[$];
	logic [31:0] got;
	logic [31:0] b1;
	int n_mismatch = 0;
	int total_checks = 0;
	int n_loaded = 0;
	int cyc = 0;
	tcp_link_if link();
	// Clock of 40 ns
	always #20 clk_sys = ~clk_sys;
	tcp_host_end tcp_host_end_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link.host), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
	// Small FIFO so that overflow is cheap to reach
	tcp_dev_end #(.DEPTH(8)) tcp_dev_end_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link.dev),
		.rd_valid(rd_valid), .rd_data(rd_data), .rd_mask(rd_mask), .rd_ready(rd_ready),
		.tx_error_flag(tx_error_flag), .err_clear(err_clear), .buffer_loaded_flag(buffer_loaded_flag));
	tcp_link_chk #(.DEPTH(8)) tcp_link_chk_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.dw_valid(link.dw_valid), .dw_data(link.dw_data), .free_words(link.free_words),
		.loaded_evt(link.loaded_evt), .error_evt(link.error_evt), .stat_valid(link.stat_valid),
		.stat_tag(link.stat_tag));
	// Collect words handed to the transmitter, count loaded pulses, cut a hang short
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (rd_valid === 1'b1 && rd_ready === 1'b1) q.push_back({rd_mask, rd_data});
		if (buffer_loaded_flag === 1'b1) n_loaded++;
		if (cyc == 5000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk_val(input logic [35:0] g, input logic [35:0] e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// An empty queue yields unknown, which never matches
	task automatic chk_fifo(input logic [35:0] e);
		chk_val((q.size() > 0) ? q.pop_front() : 36'hX_XXXX_XXXX, e);
	endtask
	// Strobe stays up for a following access; idle lowers it
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		@(posedge clk_sys);
		rd <= 1'b0;
		@(posedge clk_sys);
		// Read data stand only in the cycle after the strobe; taken at its closing edge
		d = rdata;
	endtask
	// Command pair, payload words A5000000+i, then padding; busy host needs the gaps
	task automatic send_buf(input logic [31:0] a, input logic [31:0] b, input int n);
		wr_reg(8'h00, a);
		wr_reg(8'h04, b);
		wr_reg(8'h0C, 32'h0000_0001);
		idle(3);
		for (int i = 0; i < n; i++) wr_reg(8'h08, 32'hA500_0000 | i);
		wr_reg(8'h0C, 32'h0000_0002);
		idle(12);
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rd_reg(8'h18, got);
		chk_val(36'(got), 36'h0_0000_0008);
		rd_reg(8'h40, got);
		chk_val(36'(got), 36'h0_0000_0000);
		// Single buffer with completion interrupt
		wr_reg(8'h14, 32'h0000_0001);
		// Reserved A bits set in the register; the link must carry them cleared
		send_buf(32'hFC00_3005, 32'h1234_0005, 2);
		chk_fifo({4'hF, 32'hA500_0000});
		chk_fifo({4'h1, 32'hA500_0001});
		chk_val(36'(irq), 36'h0_0000_0001);
		chk_val(36'(n_loaded), 36'h0_0000_0001);
		rd_reg(8'h10, got);
		chk_val(36'(got), 36'h0_0000_0005);
		rd_reg(8'h1C, got);
		chk_val(36'(got), 36'h0_0000_1234);
		rd_reg(8'h00, got);
		chk_val(36'(got), 36'h0_FC00_3005);
		wr_reg(8'h10, 32'h0000_0007);
		idle(2);
		chk_val(36'(irq), 36'h0_0000_0000);
		// Every alignment code, offset 3, six bytes: lanes 8, F, 1 and padding dropped
		for (int c = 0; c < 4; c++) begin
			send_buf(32'h0003_3006 | (c << 24), 32'h0000_0006 | (c << 16), 3);
			chk_fifo({4'h8, 32'hA500_0000});
			chk_fifo({4'hF, 32'hA500_0001});
			chk_fifo({4'h1, 32'hA500_0002});
			chk_val(36'(q.size()), 36'h0_0000_0000);
			chk_val(36'(tx_error_flag), (c == 3) ? 36'h1 : 36'h0);
			err_clear <= 1'b1;
			@(posedge clk_sys);
			err_clear <= 1'b0;
			wr_reg(8'h10, 32'h0000_0007);
			idle(2);
		end
		// Two-buffer packets: matching, differing B, wrong length
		for (int k = 0; k < 3; k++) begin
			b1 = (k == 2) ? 32'h00AA_0009 : 32'h00AA_0008;
			send_buf(32'h0000_2004, b1, 1);
			send_buf(32'h0000_1004, (k == 1) ? 32'h00AB_0008 : b1, 1);
			chk_val(36'(q.size()), 36'h0_0000_0002);
			q.delete();
			chk_val(36'(tx_error_flag), (k == 0) ? 36'h0 : 36'h1);
			rd_reg(8'h1C, got);
			chk_val(36'(got), 36'h0_0000_00AA);
			err_clear <= 1'b1;
			@(posedge clk_sys);
			err_clear <= 1'b0;
			@(posedge clk_sys);
		end
		// Ten words into an eight-word FIFO with the transmitter stalled
		rd_ready <= 1'b0;
		send_buf(32'h0000_3028, 32'h0000_0028, 10);
		rd_reg(8'h18, got);
		chk_val(36'(got), 36'h0_0000_0000);
		chk_val(36'(tx_error_flag), 36'h0_0000_0001);
		rd_ready <= 1'b1;
		idle(12);
		chk_val(36'(q.size()), 36'h0_0000_0008);
		stop_test();
	end
endmodule
`default_nettype wire
